// [stoc_pkg.sv]
// Contract
// - Diagnostic view lights one segment per pin
// - Forced outputs driven per pin individually
// - Forcing outputs only while servo-on is off
// - Test refused with absolute position system
// - No test entry while servo-on active
// - Jog only without external motion command
// - Up turns CCW, down turns CW, release stops
// - Test speed default 200, limited to max
// - Accel time default 1000 ms, 0 to 50000
// - Host link loss in jog: ramped stop
// - Mode steps screens, cycles back, ignores up/down
// - Jog ends on next screen plus 2 s set
// - Positioning runs preset distance once per command
// - Forward command CCW, reverse command CW
// - Pause stops, second pause clears, resume continues
// - Host link loss in positioning: abrupt stop
// - Motor-less mode mimics motor from external inputs
// - Motor-less only after servo-on off; power leaves
package stoc_pkg;

  // ****************************************************************
  // Sizes and defaults
  // ****************************************************************
  localparam int unsigned NUM_IN        = 8;
  localparam int unsigned NUM_OUT       = 8;
  localparam int unsigned SPD_W         = 16;
  localparam int unsigned ACC_W         = 16;
  localparam int unsigned DIST_W        = 24;
  localparam int unsigned SCR_W         = 4;
  localparam logic [SPD_W-1:0]  SPEED_DEF = 16'h00C8;   // 200 r/min
  localparam logic [ACC_W-1:0]  ACC_DEF   = 16'h03E8;   // 1000 ms
  localparam logic [ACC_W-1:0]  ACC_MAX   = 16'hC350;   // 50000 ms
  localparam logic [DIST_W-1:0] DIST_DEF  = 24'h002710; // 10000 pulses
  localparam logic [DIST_W-1:0] DIST_MAX  = 24'h98967F; // 9999999 pulses
  localparam logic [SCR_W-1:0]  SCR_LAST  = 4'h7;       // Last status screen

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SET_HOLD_MS   = 2000;
  localparam longint unsigned SET_HOLD_CYC = longint'(SET_HOLD_MS) * CLK_HZ / 1000;
  localparam int unsigned MS_CYC        = CLK_HZ / 1000;
  localparam int unsigned TMR_W         = 32;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_JOG   = 5'b00010,
    ST_POS   = 5'b00100,
    ST_PAUSE = 5'b01000,
    ST_MLESS = 5'b10000
  } stoc_mode_type;

  typedef enum logic [1:0] {
    SEL_JOG   = 2'h0,
    SEL_POS   = 2'h1,
    SEL_MLESS = 2'h2,
    SEL_FORCE = 2'h3
  } stoc_sel_type;

  typedef struct packed {
    logic forward;   // Start CCW move
    logic reverse;   // Start CW move
    logic pause;     // Pause / clear remaining
    logic jog_ccw;   // Host jog CCW held
    logic jog_cw;    // Host jog CW held
    logic link_ok;   // Cable connected
  } stoc_host_cmd_type;

  typedef struct packed {
    logic up;
    logic down;
    logic mode;
    logic set;
  } stoc_keys_type;

  typedef struct packed {
    logic                run;     // Motion commanded
    logic                ccw;     // Direction, 1 = CCW
    logic                ramp;    // 1 = use accel ramp on stop
    logic [SPD_W-1:0]    speed;   // r/min
    logic [ACC_W-1:0]    acc_ms;  // Ramp time
  } stoc_motion_type;

endpackage : stoc_pkg

// [stoc_hold_timer.sv]
`timescale 1ns/10ps
// ****************************************************************
// Button hold timer: pulses once after a long press
// ****************************************************************
module stoc_hold_timer (
  input  wire logic clock_i,  // System clock
  input  wire logic rst_n_i,  // Sync reset, low
  input  wire logic level_i,  // Button level
  output logic      done_o    // One-cycle pulse at hold time
);
  localparam logic [stoc_pkg::TMR_W-1:0] LIMIT =
    stoc_pkg::TMR_W'(stoc_pkg::SET_HOLD_CYC - 1);

  logic [stoc_pkg::TMR_W-1:0] cnt_q;
  logic                       fired_q;

  // Count while held; fire once per press so a long hold cannot retrigger
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !level_i) begin
      cnt_q   <= '0;
      fired_q <= 1'b0;
      done_o  <= 1'b0;
    end else if (cnt_q == LIMIT && !fired_q) begin
      fired_q <= 1'b1;
      done_o  <= 1'b1;
    end else begin
      done_o <= 1'b0;
      if (cnt_q != LIMIT) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule : stoc_hold_timer

// [stoc_test_ctrl.sv]
`timescale 1ns/10ps
module stoc_test_ctrl (
  input  wire logic                                clock_i,          // 100 MHz
  input  wire logic                                rst_n_i,          // Sync reset
  input  wire logic [stoc_pkg::NUM_IN-1:0]         din_i,            // Input pins
  input  wire logic [stoc_pkg::NUM_OUT-1:0]        dout_i,           // Normal outputs
  input  wire logic                                servo_on_input,   // Servo-on level
  input  wire logic                                forced_stop_input, // 1 = released
  input  wire logic                                abs_system_i,     // 1 = absolute
  input  wire logic                                ext_cmd_i,        // External motion cmd
  input  wire stoc_pkg::stoc_keys_type             keys_i,           // Panel edges/levels
  input  wire stoc_pkg::stoc_sel_type              sel_i,            // Diagnostic choice
  input  wire logic                                sel_go_i,         // Confirm choice pulse
  input  wire logic [stoc_pkg::NUM_OUT-1:0]        force_val_i,      // Forced levels
  input  wire logic                                force_en_i,       // Forcing requested
  input  wire stoc_pkg::stoc_host_cmd_type         host_i,           // Host commands
  input  wire logic                                cfg_we_i,         // Host config write
  input  wire logic [stoc_pkg::SPD_W-1:0]          cfg_speed_i,      // Speed value
  input  wire logic [stoc_pkg::ACC_W-1:0]          cfg_acc_i,        // Ramp value
  input  wire logic [stoc_pkg::DIST_W-1:0]         cfg_dist_i,       // Distance value
  input  wire logic [stoc_pkg::SPD_W-1:0]          speed_max_i,      // Inst. permissible
  input  wire logic                                pulse_i,          // One feedback pulse
  output logic [stoc_pkg::NUM_IN-1:0]              seg_in_o,         // Upper segments
  output logic [stoc_pkg::NUM_OUT-1:0]             seg_out_o,        // Lower segments
  output logic [stoc_pkg::NUM_OUT-1:0]             pin_out_o,        // Output pins
  output stoc_pkg::stoc_motion_type                motion_o,         // Motor command
  output logic                                     motor_less_o,     // Simulated motor
  output logic [stoc_pkg::SCR_W-1:0]               screen_o,         // 0 = ready screen
  output logic [4:0]                               mode_o,           // One-hot mode
  output logic                                     refused_o         // Last request refused
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  stoc_pkg::stoc_mode_type    mode_q;
  logic [stoc_pkg::SPD_W-1:0] speed_q;
  logic [stoc_pkg::ACC_W-1:0] acc_q;
  logic [stoc_pkg::DIST_W-1:0] dist_q;
  logic [stoc_pkg::DIST_W-1:0] remain_q;
  logic                       dir_ccw_q;
  logic                       forcing_q;
  logic                       set_long;
  logic                       test_ok;
  logic                       move_ok;
  logic                       link_lost;
  logic [stoc_pkg::SPD_W-1:0] spd_lim;

  // Entry allowed only with incremental system and servo off
  assign test_ok   = !abs_system_i && !servo_on_input;
  assign move_ok   = forced_stop_input;
  assign link_lost = !host_i.link_ok;
  assign spd_lim   = (speed_q > speed_max_i) ? speed_max_i : speed_q;

  // ****************************************************************
  // Set-button long press
  // ****************************************************************
  stoc_hold_timer u_hold (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .level_i (keys_i.set),
    .done_o  (set_long)
  );

  // ****************************************************************
  // I/O display, sampled live
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < stoc_pkg::NUM_IN; gi++) begin : g_in
      // One upper segment per input pin
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          seg_in_o[gi] <= 1'b0;
        end else begin
          seg_in_o[gi] <= din_i[gi];
        end
      end
    end
    for (gi = 0; gi < stoc_pkg::NUM_OUT; gi++) begin : g_out
      // Each output forced independently; lower segment mirrors the pin
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          pin_out_o[gi] <= 1'b0;
          seg_out_o[gi] <= 1'b0;
        end else if (forcing_q) begin
          pin_out_o[gi] <= force_val_i[gi];
          seg_out_o[gi] <= force_val_i[gi];
        end else begin
          pin_out_o[gi] <= dout_i[gi];
          seg_out_o[gi] <= dout_i[gi];
        end
      end
    end
  endgenerate

  // Forcing drops on the next clock if servo-on rises, protecting brake lines
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      forcing_q <= 1'b0;
    end else begin
      forcing_q <= force_en_i && !servo_on_input && (mode_q == stoc_pkg::ST_IDLE);
    end
  end

  // ****************************************************************
  // Test condition settings from host
  // ****************************************************************
  // Out-of-range values are clamped rather than dropped
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      speed_q <= stoc_pkg::SPEED_DEF;
      acc_q   <= stoc_pkg::ACC_DEF;
      dist_q  <= stoc_pkg::DIST_DEF;
    end else if (cfg_we_i && host_i.link_ok) begin
      speed_q <= cfg_speed_i;
      acc_q   <= (cfg_acc_i > stoc_pkg::ACC_MAX) ? stoc_pkg::ACC_MAX : cfg_acc_i;
      dist_q  <= (cfg_dist_i > stoc_pkg::DIST_MAX) ? stoc_pkg::DIST_MAX : cfg_dist_i;
    end
  end

  // ****************************************************************
  // Status screen stepping
  // ****************************************************************
  // Only mode key steps; up/down drive the jog instead
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || mode_q == stoc_pkg::ST_IDLE) begin
      screen_o <= '0;
    end else if (keys_i.mode) begin
      screen_o <= (screen_o == stoc_pkg::SCR_LAST) ? '0 : screen_o + 1'b1;
    end
  end

  // ****************************************************************
  // Test mode machine
  // ****************************************************************
  // Single state register keeps the test modes exclusive
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mode_q    <= stoc_pkg::ST_IDLE;
      refused_o <= 1'b0;
    end else begin
      unique case (mode_q)
        stoc_pkg::ST_IDLE: begin
          if (sel_go_i && sel_i != stoc_pkg::SEL_FORCE) begin
            refused_o <= !test_ok;
            if (test_ok) begin
              unique case (sel_i)
                stoc_pkg::SEL_JOG:   mode_q <= stoc_pkg::ST_JOG;
                stoc_pkg::SEL_POS:   mode_q <= stoc_pkg::ST_POS;
                stoc_pkg::SEL_MLESS: mode_q <= stoc_pkg::ST_MLESS;
                default:             mode_q <= stoc_pkg::ST_IDLE;
              endcase
            end
          end
        end
        stoc_pkg::ST_JOG: begin
          // Exit only off the ready screen with a long set press
          if (set_long && screen_o != '0) begin
            mode_q <= stoc_pkg::ST_IDLE;
          end
        end
        stoc_pkg::ST_POS: begin
          if (host_i.pause && remain_q != '0) begin
            mode_q <= stoc_pkg::ST_PAUSE;
          end
        end
        stoc_pkg::ST_PAUSE: begin
          if ((host_i.forward && dir_ccw_q) || (host_i.reverse && !dir_ccw_q)) begin
            mode_q <= stoc_pkg::ST_POS;
          end
        end
        stoc_pkg::ST_MLESS: begin
          mode_q <= stoc_pkg::ST_MLESS;
        end
      endcase
    end
  end

  // ****************************************************************
  // Positioning distance
  // ****************************************************************
  // Second pause clears the rest so a resume starts nothing
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      remain_q  <= '0;
      dir_ccw_q <= 1'b0;
    end else if (mode_q == stoc_pkg::ST_POS) begin
      if (link_lost) begin
        remain_q <= '0;
      end else if (remain_q == '0 && move_ok && !ext_cmd_i
                   && (host_i.forward || host_i.reverse)) begin
        remain_q  <= dist_q;
        dir_ccw_q <= host_i.forward;
      end else if (pulse_i && remain_q != '0) begin
        remain_q <= remain_q - 1'b1;
      end
    end else if (mode_q == stoc_pkg::ST_PAUSE) begin
      if (host_i.pause || link_lost) begin
        remain_q <= '0;
      end
    end else begin
      remain_q <= '0;
    end
  end

  // ****************************************************************
  // Motion command
  // ****************************************************************
  // Jog stops on key release with the normal ramp
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      motion_o <= '0;
    end else begin
      motion_o.speed  <= spd_lim;
      motion_o.acc_ms <= acc_q;
      motion_o.ramp   <= 1'b1;
      motion_o.run    <= 1'b0;
      motion_o.ccw    <= motion_o.ccw;
      unique case (mode_q)
        stoc_pkg::ST_JOG: begin
          if (move_ok && !ext_cmd_i) begin
            if (keys_i.up ^ keys_i.down) begin
              motion_o.run <= 1'b1;
              motion_o.ccw <= keys_i.up;
            end else if (host_i.link_ok && (host_i.jog_ccw ^ host_i.jog_cw)) begin
              motion_o.run <= 1'b1;
              motion_o.ccw <= host_i.jog_ccw;
            end
          end
          if (link_lost) begin
            motion_o.ramp <= 1'b1;
          end
        end
        stoc_pkg::ST_POS: begin
          motion_o.run  <= (remain_q != '0) && !link_lost && move_ok;
          motion_o.ccw  <= dir_ccw_q;
          motion_o.ramp <= !link_lost;
        end
        default: begin
          motion_o.run <= 1'b0;
        end
      endcase
    end
  end

  // Motor-less flag and mode mirror
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      motor_less_o <= 1'b0;
      mode_o       <= stoc_pkg::ST_IDLE;
    end else begin
      motor_less_o <= (mode_q == stoc_pkg::ST_MLESS);
      mode_o       <= mode_q;
    end
  end

endmodule : stoc_test_ctrl

// [stoc_motor_model.sv]
`timescale 1ns/10ps
// ****
// Motor feedback model: one pulse per travelled step
// ****
module stoc_motor_model (
  input  wire logic clock_i,  // System clock
  input  wire logic rst_n_i,  // Sync reset, low
  input  wire logic run_i,    // Motion commanded
  input  wire logic slow_i,   // Long step spacing
  output logic      pulse_o   // One-cycle feedback pulse
);
  logic [3:0] step_q;
  // Step spacing of 4 or 9 cycles, so a count never races the stop
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !run_i || step_q == (slow_i ? 4'h8 : 4'h3)) begin
      step_q <= 4'h0;
    end else begin
      step_q <= step_q + 4'h1;
    end
  end
  // A still shaft gives no feedback, the line rests low
  always_ff @(posedge clock_i) begin
    pulse_o <= rst_n_i && run_i && step_q == (slow_i ? 4'h8 : 4'h3);
  end
endmodule : stoc_motor_model

// [stoc_test_ctrl_properties.sv]
`timescale 1ns/10ps
// ****
// Port checker of the test controller
// ****
module stoc_test_ctrl_properties (
  input wire logic                        clock_i,           // Clock
  input wire logic                        rst_n_i,           // Sync reset
  input wire logic [7:0]                  din_i,             // Input pins
  input wire logic [7:0]                  dout_i,            // Normal outputs
  input wire logic                        servo_on_input,    // Servo-on
  input wire logic                        forced_stop_input, // 1 = released
  input wire logic                        abs_system_i,      // Absolute system
  input wire logic                        ext_cmd_i,         // External command
  input wire stoc_pkg::stoc_keys_type     keys_i,            // Panel keys
  input wire stoc_pkg::stoc_sel_type      sel_i,             // Choice
  input wire logic                        sel_go_i,          // Confirm
  input wire stoc_pkg::stoc_host_cmd_type host_i,            // Host commands
  input wire logic [7:0]                  seg_in_o,          // Upper segments
  input wire logic [7:0]                  pin_out_o,         // Output pins
  input wire stoc_pkg::stoc_motion_type   motion_o,          // Motor command
  input wire logic [3:0]                  screen_o,          // Screen
  input wire logic [4:0]                  mode_o,            // One-hot mode
  input wire logic                        refused_o          // Refused
);
  // One domain, reset silences every check
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_mode_one_hot: assert property ($onehot(mode_o))
    else $error("mode not one-hot");
  chk_seg_in_follow: assert property ($past(rst_n_i) |-> seg_in_o == $past(din_i))
    else $error("input segments lag wrong");
  chk_force_blocked: assert property ($past(rst_n_i) && $past(servo_on_input, 2)
    |-> pin_out_o == $past(dout_i)) else $error("outputs forced while servo on");
  chk_refuse_abs: assert property (mode_o == 5'h01 && sel_go_i && abs_system_i
    && sel_i != stoc_pkg::SEL_FORCE |=> refused_o ##1 mode_o == 5'h01)
    else $error("test entered with absolute system");
  chk_refuse_servo: assert property (mode_o == 5'h01 && sel_go_i && servo_on_input
    && sel_i != stoc_pkg::SEL_FORCE |=> refused_o ##1 mode_o == 5'h01)
    else $error("test entered with servo on");
  chk_mless_sticky: assert property (mode_o == 5'h10 |=> mode_o == 5'h10)
    else $error("motor-less mode left");
  chk_ext_blocks: assert property (mode_o == 5'h02 && ext_cmd_i |=> !motion_o.run)
    else $error("jog ran with external command");
  chk_jog_up_ccw: assert property (mode_o == 5'h02 && keys_i.up && !keys_i.down
    && !ext_cmd_i && forced_stop_input |=> motion_o.run && motion_o.ccw)
    else $error("up key did not run ccw");
  chk_link_abrupt: assert property (mode_o == 5'h04 && motion_o.run && !host_i.link_ok
    |=> !motion_o.run && !motion_o.ramp) else $error("link loss stop not abrupt");
  chk_screen_step: assert property (mode_o == 5'h02 && keys_i.mode |=> screen_o ==
    ($past(screen_o) == 4'h7 ? 4'h0 : $past(screen_o) + 4'h1)) else $error("screen step wrong");
endmodule : stoc_test_ctrl_properties

// [tb.sv]
`timescale 1ns/10ps
// ****
// Testbench of the test controller
// ****
module tb;
  logic                        clock_i, rst_n_i, servo_on_input, forced_stop_input;
  logic                        abs_system_i, ext_cmd_i, sel_go_i, force_en_i, cfg_we_i;
  logic                        pulse_i, motor_less_o, refused_o, slow;
  logic [7:0]                  din_i, dout_i, force_val_i, seg_in_o, seg_out_o, pin_out_o;
  logic [15:0]                 cfg_speed_i, cfg_acc_i, speed_max_i;
  logic [23:0]                 cfg_dist_i;
  logic [3:0]                  screen_o;
  logic [4:0]                  mode_o;
  stoc_pkg::stoc_keys_type     keys_i;
  stoc_pkg::stoc_sel_type      sel_i;
  stoc_pkg::stoc_host_cmd_type host_i;
  stoc_pkg::stoc_motion_type   motion_o;
  int                          err_total, num_checks, cnt;
  stoc_test_ctrl i_stoc_test_ctrl (.clock_i(clock_i), .rst_n_i(rst_n_i), .din_i(din_i),
    .dout_i(dout_i), .servo_on_input(servo_on_input), .forced_stop_input(forced_stop_input),
    .abs_system_i(abs_system_i), .ext_cmd_i(ext_cmd_i), .keys_i(keys_i), .sel_i(sel_i),
    .sel_go_i(sel_go_i), .force_val_i(force_val_i), .force_en_i(force_en_i), .host_i(host_i),
    .cfg_we_i(cfg_we_i), .cfg_speed_i(cfg_speed_i), .cfg_acc_i(cfg_acc_i),
    .cfg_dist_i(cfg_dist_i), .speed_max_i(speed_max_i), .pulse_i(pulse_i),
    .seg_in_o(seg_in_o), .seg_out_o(seg_out_o), .pin_out_o(pin_out_o), .motion_o(motion_o),
    .motor_less_o(motor_less_o), .screen_o(screen_o), .mode_o(mode_o), .refused_o(refused_o));
  stoc_motor_model i_stoc_motor_model (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .run_i(motion_o.run), .slow_i(slow), .pulse_o(pulse_i));
  // Free-running 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Inputs move 1 ns after the edge, outputs are read there too
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Positioning and motor-less modes leave only through reset, so each scenario starts here
  task automatic do_reset;
    rst_n_i = 1'b0;
    {servo_on_input, abs_system_i, ext_cmd_i, sel_go_i, force_en_i, cfg_we_i, slow} = '0;
    forced_stop_input = 1'b1;
    {din_i, dout_i, force_val_i, cfg_speed_i, cfg_acc_i, cfg_dist_i, keys_i} = '0;
    speed_max_i = 16'hFFFF;
    sel_i = stoc_pkg::SEL_JOG;
    host_i = 6'h01;
    tick(4);
    rst_n_i = 1'b1;
  endtask : do_reset
  task automatic enter(input stoc_pkg::stoc_sel_type s);
    sel_i = s;
    sel_go_i = 1'b1;
    tick(1);
    sel_go_i = 1'b0;
    tick(2);
  endtask : enter
  // Host buttons are one-cycle pulses
  task automatic hcmd(input logic [5:0] v);
    host_i = host_i | v;
    tick(1);
    host_i = host_i & ~v;
  endtask : hcmd
  // Bounded wait on the run flag, counting feedback pulses meanwhile
  task automatic wait_run(input logic v);
    cnt = 0;
    for (int k = 0; k < 2000 && motion_o.run !== v; k++) begin
      cnt = cnt + int'(pulse_i);
      tick(1);
    end
    chk(16'(motion_o.run), 16'(v));
  endtask : wait_run
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    final_report;
  end
  initial begin
    do_reset;
    chk(16'(mode_o), 16'h0001);
    din_i = 8'hA5;
    dout_i = 8'h3C;
    force_val_i = 8'h96;
    force_en_i = 1'b1;
    servo_on_input = 1'b1;
    tick(3);
    chk(16'(seg_in_o), 16'h00A5);
    chk(16'(pin_out_o), 16'h003C);
    chk(16'(seg_out_o), 16'h003C);
    servo_on_input = 1'b0;
    tick(3);
    chk(16'(pin_out_o), 16'h0096);
    force_val_i = 8'h97;
    tick(2);
    chk(16'(pin_out_o), 16'h0097);
    chk(16'(seg_out_o), 16'h0097);
    // Every test mode refused under either blocking condition
    for (int j = 0; j < 6; j++) begin
      do_reset;
      abs_system_i = j < 3;
      servo_on_input = j >= 3;
      enter(stoc_pkg::stoc_sel_type'(j % 3));
      chk(16'(refused_o), 16'h0001);
      chk(16'(mode_o), 16'h0001);
    end
    do_reset;
    enter(stoc_pkg::SEL_JOG);
    chk(16'(mode_o), 16'h0002);
    keys_i.up = 1'b1;
    tick(2);
    chk(16'({motion_o.run, motion_o.ccw}), 16'h0003);
    chk(motion_o.speed, 16'h00C8);
    chk(motion_o.acc_ms, 16'h03E8);
    keys_i = 4'h4;
    tick(2);
    chk(16'({motion_o.run, motion_o.ccw}), 16'h0002);
    keys_i = 4'h0;
    tick(2);
    chk(16'(motion_o.run), 16'h0000);
    ext_cmd_i = 1'b1;
    keys_i.up = 1'b1;
    tick(2);
    chk(16'(motion_o.run), 16'h0000);
    ext_cmd_i = 1'b0;
    speed_max_i = 16'h0064;
    cfg_speed_i = 16'h00C8;
    cfg_acc_i = 16'hEA60;
    cfg_we_i = 1'b1;
    tick(1);
    cfg_we_i = 1'b0;
    tick(2);
    chk(motion_o.speed, 16'h0064);
    chk(motion_o.acc_ms, 16'hC350);
    keys_i.up = 1'b0;
    host_i.jog_ccw = 1'b1;
    tick(2);
    host_i.link_ok = 1'b0;
    tick(2);
    chk(16'({motion_o.run, motion_o.ramp}), 16'h0001);
    host_i = 6'h01;
    // Down toggles, up stays low, while mode steps through all screens
    for (int i = 1; i <= 8; i++) begin
      keys_i = {1'b0, i[0], 1'b1, 1'b0};
      tick(1);
      keys_i.mode = 1'b0;
      tick(1);
      chk(16'(screen_o), 16'(i % 8));
    end
    do_reset;
    enter(stoc_pkg::SEL_POS);
    chk(16'(mode_o), 16'h0004);
    cfg_speed_i = 16'h00C8;
    cfg_acc_i = 16'h03E8;
    cfg_dist_i = 24'h000005;
    cfg_we_i = 1'b1;
    tick(1);
    cfg_we_i = 1'b0;
    for (int d = 0; d < 2; d++) begin
      slow = d[0];
      hcmd(d == 0 ? 6'h20 : 6'h10);
      wait_run(1'b1);
      chk(16'(motion_o.ccw), 16'(d == 0));
      wait_run(1'b0);
      chk(16'(cnt), 16'h0005);
    end
    slow = 1'b0;
    hcmd(6'h20);
    wait_run(1'b1);
    tick(6);
    hcmd(6'h08);
    tick(2);
    chk(16'({mode_o, motion_o.run}), 16'h0010);
    hcmd(6'h20);
    wait_run(1'b1);
    wait_run(1'b0);
    chk(16'(cnt < 5), 16'h0001);
    // Second pause drops the rest, so a resume moves nothing
    hcmd(6'h20);
    wait_run(1'b1);
    tick(6);
    hcmd(6'h08);
    tick(2);
    hcmd(6'h08);
    tick(2);
    hcmd(6'h20);
    tick(4);
    chk(16'({mode_o, motion_o.run}), 16'h0008);
    forced_stop_input = 1'b0;
    hcmd(6'h20);
    tick(4);
    chk(16'(motion_o.run), 16'h0000);
    forced_stop_input = 1'b1;
    hcmd(6'h20);
    wait_run(1'b1);
    host_i.link_ok = 1'b0;
    tick(2);
    chk(16'({motion_o.run, motion_o.ramp}), 16'h0000);
    do_reset;
    enter(stoc_pkg::SEL_MLESS);
    chk(16'({mode_o, motor_less_o}), 16'h0021);
    enter(stoc_pkg::SEL_JOG);
    chk(16'(mode_o), 16'h0010);
    final_report;
  end
endmodule : tb
bind stoc_test_ctrl stoc_test_ctrl_properties i_stoc_test_ctrl_properties (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .din_i(din_i), .dout_i(dout_i),
  .servo_on_input(servo_on_input), .forced_stop_input(forced_stop_input),
  .abs_system_i(abs_system_i), .ext_cmd_i(ext_cmd_i), .keys_i(keys_i), .sel_i(sel_i),
  .sel_go_i(sel_go_i), .host_i(host_i), .seg_in_o(seg_in_o), .pin_out_o(pin_out_o),
  .motion_o(motion_o), .screen_o(screen_o), .mode_o(mode_o), .refused_o(refused_o));
